// ---- hdl/src_top.sv ----
/*
 * System reset controller: merges power on/off, external pin, low voltage
 * and watchdog reset sources into one system reset, and sets boot address,
 * clock source and oscillator enable. Registers sit on an APB slave.
 * Assumes analog detector outputs and the pin sample are asynchronous to pclk
 * and that presetn is the always-on power-up reset of this block.
 */
// Design decisions made here: the address map and the APB slave port.
// How it works
// - Any of power on/off, the filtered pin low, a low voltage or a watchdog timeout resets.
// - While the system reset is active every control register is held at its default.
// - Power on/off reset is asserted while the core rail is below 90% or below 75%.
// - The main supply detector threshold is a software register driven out.
// - The low voltage reset is off after reset and acts only once software enables it.
// - The core supply low voltage detector may be added to the low voltage reset condition.
// - While a low voltage reset condition stands the pin is driven low.
// - Low pulses on the pin shorter than 5 us are ignored.
// - After any reset the watchdog and its reset output are both disabled.
// - On release the program counter is loaded with 0x0F000.
// - After reset the internal oscillator is the system clock source.
// - The internal oscillator runs in every power mode except stop and sleep.
`include "src_params.svh"

module src_top
    import src_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Supply detectors
    input wire logic core_rail_below_90,
    input wire logic core_rail_below_75,
    input wire logic core_supply_low_voltage_detector,
    input wire logic main_supply_low_voltage_detector,
    output logic [3:0] lvd_threshold,
    // External reset pin, open drain
    input wire logic external_reset_pin_i,
    output logic external_reset_pin_o,
    output logic external_reset_pin_oe_n,
    // System outputs
    output logic sys_rst_n,
    output logic pc_load,
    output logic [19:0] pc_boot_addr,
    output logic clk_sel_ext,
    output logic internal_oscillator_en,
    output logic watchdog_en
);
    localparam logic [4:0] HOLD_CYC = 5'(`SRC_HOLD_CYC);

    src_filt_if fif ();
    src_pin_filter u_filt (
        .pclk (pclk),
        .presetn (presetn),
        .fif (fif.filt)
    );

    // Two-flop synchronisers for the detector levels and the pin.
    logic [4:0] async_in;
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    assign async_in = {!external_reset_pin_i, main_supply_low_voltage_detector,
                       core_supply_low_voltage_detector, core_rail_below_75,
                       core_rail_below_90};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate
    assign fif.pin_low = sync2_r[4];

    logic [`SRC_CTRL_W-1:0] ctrl_r;
    logic [3:0] lvdthr_r;
    logic [15:0] wdtload_r;
    logic [15:0] wdt_cnt_r;
    logic [3:0] cause_r;
    src_state_e state_r;
    src_state_e state_nxt;
    logic [4:0] hold_r;
    logic in_rst;
    logic por_src;
    logic lvr_cond;
    logic wdt_src;
    logic [3:0] src_vec;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic lvr_hold_r;

    assign por_src = sync2_r[0] || sync2_r[1];
    assign lvr_cond = (sync2_r[3] && ctrl_r[`SRC_CTRL_LVR_EN])
                      || (sync2_r[2] && ctrl_r[`SRC_CTRL_CORE_EN]);
    assign wdt_src = ctrl_r[`SRC_CTRL_WDT_EN] && ctrl_r[`SRC_CTRL_WDT_RST]
                     && (wdt_cnt_r == wdtload_r);
    assign src_vec = {wdt_src, lvr_cond, fif.filt_low, por_src};
    assign in_rst = (state_r != SRC_ST_RUN);

    // Sequencer: enter on any source, hold a fixed time after all clear.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SRC_ST_RESET: begin
                if (src_vec == 4'h0) begin
                    state_nxt = SRC_ST_HOLD;
                end
            end
            SRC_ST_HOLD: begin
                if (src_vec != 4'h0) begin
                    state_nxt = SRC_ST_RESET;
                end else if (hold_r == HOLD_CYC - 5'd1) begin
                    state_nxt = SRC_ST_RUN;
                end
            end
            SRC_ST_RUN: begin
                if (src_vec != 4'h0) begin
                    state_nxt = SRC_ST_RESET;
                end
            end
            default: state_nxt = SRC_ST_RESET;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= SRC_ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 5'd0;
        end else if (state_r == SRC_ST_HOLD) begin
            hold_r <= hold_r + 5'd1;
        end else begin
            hold_r <= 5'd0;
        end
    end

    // APB decode; one wait state so read data comes from a flop. A write lands
    // only on the edge that completes the transfer, when pready is high.
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && penable && !pwrite && !pready;
    assign addr_ok = (paddr == `SRC_OFF_CTRL) || (paddr == `SRC_OFF_LVDTHR)
                     || (paddr == `SRC_OFF_WDTLOAD) || (paddr == `SRC_OFF_WDTKICK)
                     || (paddr == `SRC_OFF_STATUS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                `SRC_OFF_CTRL: prdata <= {25'h000_0000, ctrl_r};
                `SRC_OFF_LVDTHR: prdata <= {28'h000_0000, lvdthr_r};
                `SRC_OFF_WDTLOAD: prdata <= {16'h0000, wdtload_r};
                `SRC_OFF_STATUS: prdata <= {24'h00_0000, lvr_cond, fif.filt_low,
                                            state_r, cause_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Writes are ignored while the system is in reset, so defaults stand.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `SRC_CTRL_RST;
        end else if (in_rst) begin
            ctrl_r <= `SRC_CTRL_RST;
        end else if (wr_en && paddr == `SRC_OFF_CTRL) begin
            ctrl_r <= pwdata[`SRC_CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvdthr_r <= `SRC_LVDTHR_RST;
        end else if (in_rst) begin
            lvdthr_r <= `SRC_LVDTHR_RST;
        end else if (wr_en && paddr == `SRC_OFF_LVDTHR) begin
            lvdthr_r <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdtload_r <= `SRC_WDTLOAD_RST;
        end else if (in_rst) begin
            wdtload_r <= `SRC_WDTLOAD_RST;
        end else if (wr_en && paddr == `SRC_OFF_WDTLOAD) begin
            wdtload_r <= pwdata[15:0];
        end
    end

    // Watchdog counter; a kick or a disable restarts it from zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_r <= 16'h0000;
        end else if (!ctrl_r[`SRC_CTRL_WDT_EN] || in_rst) begin
            wdt_cnt_r <= 16'h0000;
        end else if (wr_en && paddr == `SRC_OFF_WDTKICK) begin
            wdt_cnt_r <= 16'h0000;
        end else if (wdt_cnt_r != wdtload_r) begin
            wdt_cnt_r <= wdt_cnt_r + 16'h0001;
        end
    end

    // Reset cause flags survive the system reset; presetn leaves only the power on/off flag set.
    // A new cause in the same cycle as a write-one clear is kept.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r <= 4'h1;
        end else begin
            cause_r <= (cause_r & ~((wr_en && paddr == `SRC_OFF_STATUS) ? pwdata[3:0] : 4'h0))
                       | src_vec;
        end
    end

    // Outputs, each from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_rst_n <= 1'b0;
            pc_load <= 1'b0;
            pc_boot_addr <= `SRC_BOOT_PC;
        end else begin
            sys_rst_n <= (state_nxt == SRC_ST_RUN);
            pc_load <= (state_nxt == SRC_ST_RUN) && (state_r == SRC_ST_HOLD);
            pc_boot_addr <= `SRC_BOOT_PC;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_reset_pin_o <= 1'b0;
            external_reset_pin_oe_n <= 1'b1;
        end else begin
            external_reset_pin_oe_n <= !(lvr_cond || lvr_hold_r);
        end
    end

    // The system reset clears the enables at once, so the pull is kept while a
    // tripped detector stays low; a long enough low then lengthens the reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvr_hold_r <= 1'b0;
        end else begin
            lvr_hold_r <= lvr_cond
                          || (lvr_hold_r && (sync2_r[3] || sync2_r[2]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvd_threshold <= `SRC_LVDTHR_RST;
            clk_sel_ext <= 1'b0;
            internal_oscillator_en <= 1'b1;
            watchdog_en <= 1'b0;
        end else begin
            lvd_threshold <= lvdthr_r;
            clk_sel_ext <= ctrl_r[`SRC_CTRL_CLK_EXT] && !in_rst;
            internal_oscillator_en <= in_rst
                || (ctrl_r[`SRC_CTRL_PMODE_HI:`SRC_CTRL_PMODE_LO] != SRC_PM_STOP
                    && ctrl_r[`SRC_CTRL_PMODE_HI:`SRC_CTRL_PMODE_LO] != SRC_PM_SLEEP);
            watchdog_en <= ctrl_r[`SRC_CTRL_WDT_EN] && !in_rst;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence release_seq;
        state_r == SRC_ST_HOLD ##1 state_r == SRC_ST_RUN;
    endsequence

    src_enter_a: assert property (state_r == SRC_ST_RUN && src_vec != 4'h0
                                  |=> state_r == SRC_ST_RESET ##1 !sys_rst_n)
        else $error("reset source did not reset the system");
    regs_default_a: assert property (in_rst |=> ctrl_r == `SRC_CTRL_RST
                                     && lvdthr_r == `SRC_LVDTHR_RST)
        else $error("register not at default during reset");
    por_src_a: assert property (sync2_r[1] && !in_rst |=> in_rst)
        else $error("core rail at 75 percent did not reset");
    lvr_gate_a: assert property (!ctrl_r[`SRC_CTRL_LVR_EN] && !ctrl_r[`SRC_CTRL_CORE_EN]
                                 && !lvr_hold_r |=> external_reset_pin_oe_n)
        else $error("low voltage reset acted while disabled");
    pin_drive_a: assert property (lvr_cond |=> !external_reset_pin_oe_n
                                  && !external_reset_pin_o)
        else $error("pin not driven low during low voltage reset");
    wdt_off_a: assert property (in_rst |=> ##1 !watchdog_en && wdt_cnt_r == 16'h0000)
        else $error("watchdog active after reset");
    boot_pc_a: assert property (release_seq |-> pc_load && sys_rst_n
                                && pc_boot_addr == `SRC_BOOT_PC)
        else $error("boot address not loaded on release");
    hold_time_a: assert property ($rose(sys_rst_n) |-> $past(hold_r) == HOLD_CYC - 5'd1)
        else $error("system reset released without the hold time");
    clk_int_a: assert property (in_rst |=> !clk_sel_ext)
        else $error("external clock selected during reset");
    osc_stop_a: assert property (!in_rst && ctrl_r[`SRC_CTRL_PMODE_HI]
                                 |=> !internal_oscillator_en)
        else $error("oscillator left running in stop or sleep");
endmodule : src_top

// ---- include/src_params.svh ----
/*
 * Offsets, field positions, reset values and timing counts of the system
 * reset controller. Included by the design modules and by the bench.
 */
`ifndef SRC_PARAMS_SVH
`define SRC_PARAMS_SVH

// Register byte offsets on the APB bus.
`define SRC_OFF_CTRL 12'h000
`define SRC_OFF_LVDTHR 12'h004
`define SRC_OFF_WDTLOAD 12'h008
`define SRC_OFF_WDTKICK 12'h00C
`define SRC_OFF_STATUS 12'h010

// Control register fields.
`define SRC_CTRL_LVR_EN 0
`define SRC_CTRL_CORE_EN 1
`define SRC_CTRL_WDT_EN 2
`define SRC_CTRL_WDT_RST 3
`define SRC_CTRL_PMODE_LO 4
`define SRC_CTRL_PMODE_HI 5
`define SRC_CTRL_CLK_EXT 6
`define SRC_CTRL_W 7

// Reset values.
`define SRC_CTRL_RST 7'h00
`define SRC_LVDTHR_RST 4'h0
`define SRC_WDTLOAD_RST 16'hFFFF
`define SRC_BOOT_PC 20'h0_F000

// Timing: the pin filter and the hold of the system reset after release.
`define SRC_CLK_MHZ 250
`define SRC_FILT_US 5
`define SRC_FILT_CYC (`SRC_FILT_US * `SRC_CLK_MHZ)
`define SRC_HOLD_CYC 16

`endif

// ---- include/src_pkg.sv ----
/*
 * Types of the system reset controller.
 * Assumes src_params.svh is on the include path.
 */
package src_pkg;
    typedef enum logic [1:0] {
        SRC_ST_RESET = 2'b00,
        SRC_ST_HOLD = 2'b01,
        SRC_ST_RUN = 2'b10
    } src_state_e;

    typedef enum logic [1:0] {
        SRC_PM_RUN = 2'b00,
        SRC_PM_IDLE = 2'b01,
        SRC_PM_STOP = 2'b10,
        SRC_PM_SLEEP = 2'b11
    } src_pmode_e;
endpackage : src_pkg

// ---- include/src_filt_if.sv ----
/*
 * Link between the reset controller and its external pin filter.
 * Assumes both ends run on the same clock.
 */
interface src_filt_if;
    logic pin_low;
    logic filt_low;
    modport ctrl (output pin_low, input filt_low);
    modport filt (input pin_low, output filt_low);
endinterface : src_filt_if

// ---- hdl/src_pin_filter.sv ----
/*
 * Glitch filter for the external reset pin.
 * Assumes pin_low is already synchronous to pclk.
 */
`include "src_params.svh"

module src_pin_filter
    import src_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin sample and filtered level
    src_filt_if.filt fif
);
    localparam logic [10:0] FILT_CYC = 11'(`SRC_FILT_CYC);

    logic [10:0] low_cnt_r;
    logic filt_low_r;

    // A low shorter than the filter time never reaches the output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_r <= 11'h000;
        end else if (!fif.pin_low) begin
            low_cnt_r <= 11'h000;
        end else if (low_cnt_r != FILT_CYC) begin
            low_cnt_r <= low_cnt_r + 11'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_low_r <= 1'b0;
        end else begin
            filt_low_r <= fif.pin_low && (low_cnt_r == FILT_CYC - 11'h001);
            if (fif.pin_low && low_cnt_r == FILT_CYC) begin
                filt_low_r <= 1'b1;
            end
        end
    end

    assign fif.filt_low = filt_low_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    filt_short_a: assert property (!fif.pin_low ##1 fif.pin_low [*8] |-> !filt_low_r)
        else $error("pin filter passed a short low pulse");
    filt_count_a: assert property ($rose(filt_low_r) |-> low_cnt_r == FILT_CYC)
        else $error("pin filter fired before the filter time");
endmodule : src_pin_filter

// ---- verif/src_partner.sv ----
/*
 * Model of the reset pin circuit and of the supply monitors.
 * Assumes it shares pclk with the controller and is steered by tb tasks.
 */
module src_partner (
    // Clock
    input wire logic pclk,
    // Pin driver of the controller
    input wire logic pin_o,
    input wire logic pin_oe_n,
    // Levels seen by the controller
    output logic pin_i,
    output logic rail_90,
    output logic rail_75,
    output logic core_low,
    output logic main_low
);
    timeunit 1ns;
    timeprecision 1ps;

    logic btn_low;

    // The pull-up to the regulator wins unless the button or the controller pulls low.
    assign pin_i = !(btn_low || (!pin_oe_n && !pin_o));

    initial begin
        btn_low = 1'b0;
        {rail_90, rail_75, core_low, main_low} = 4'h0;
    end

    // Button press held low for n cycles; a reset needs at least 1250 at 250 MHz.
    task automatic press(input int n);
        @(posedge pclk);
        btn_low <= 1'b1;
        repeat (n) @(posedge pclk);
        btn_low <= 1'b0;
    endtask : press

    task automatic set_levels(input logic [3:0] v);
        @(posedge pclk);
        {rail_90, rail_75, core_low, main_low} <= v;
    endtask : set_levels
endmodule : src_partner

// ---- verif/tb.sv ----
/*
 * Self-checking bench of the system reset controller over APB.
 * Assumes src_params.svh on the include path and src_partner compiled first.
 */
`include "src_params.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end

module tb;
    import src_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, r90, r75, core_low, main_low, pin_i, pin_o, oe_n;
    logic [3:0] lvd_thr;
    logic sys_rst_n, pc_load, clk_ext, osc_en, wdt_en;
    logic [19:0] pc_addr;
    int error_cnt = 0;
    int samples_checked = 0;

    src_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_rail_below_90(r90),
        .core_rail_below_75(r75), .core_supply_low_voltage_detector(core_low),
        .main_supply_low_voltage_detector(main_low), .lvd_threshold(lvd_thr),
        .external_reset_pin_i(pin_i), .external_reset_pin_o(pin_o),
        .external_reset_pin_oe_n(oe_n), .sys_rst_n(sys_rst_n), .pc_load(pc_load),
        .pc_boot_addr(pc_addr), .clk_sel_ext(clk_ext), .internal_oscillator_en(osc_en),
        .watchdog_en(wdt_en));

    src_partner i_partner (.pclk(pclk), .pin_o(pin_o), .pin_oe_n(oe_n), .pin_i(pin_i),
        .rail_90(r90), .rail_75(r75), .core_low(core_low), .main_low(main_low));

    always #2 pclk = ~pclk;

    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // The request stays up until pready is sampled high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        `CHK("apb_wait", 2, n)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        `CHK(n, x, r)
    endtask : rd_chk

    task automatic wait_rst(input logic lvl, input int lim);
        for (int i = 0; i < lim && sys_rst_n !== lvl; i++) @(posedge pclk);
    endtask : wait_rst

    // Waits for the release and checks every default that follows a reset.
    task automatic boot;
        wait_rst(1'b1, 3000);
        `CHK("sys_rst_n", 1'b1, sys_rst_n)
        `CHK("pc_load", 1'b1, pc_load)
        `CHK("pc_boot_addr", 20'h0_F000, pc_addr)
        `CHK("clk_sel_ext", 1'b0, clk_ext)
        `CHK("osc_en", 1'b1, osc_en)
        `CHK("watchdog_en", 1'b0, wdt_en)
        `CHK("lvd_threshold", 4'h0, lvd_thr)
        rd_chk("ctrl", `SRC_OFF_CTRL, 32'h0000_0000);
        rd_chk("wdtload", `SRC_OFF_WDTLOAD, 32'h0000_FFFF);
    endtask : boot

    // Raises the given detector levels, expects a reset, then drops them.
    task automatic cycle_src(input logic [3:0] lv);
        i_partner.set_levels(lv);
        wait_rst(1'b0, 20);
        `CHK("sys_rst_n", 1'b0, sys_rst_n)
        repeat (2) @(posedge pclk);
        `CHK("pin_oe_n", lv[1:0] == 2'b00, oe_n)
        i_partner.set_levels(4'h0);
        boot();
    endtask : cycle_src

    initial begin
        #200_000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        boot();
        wr(`SRC_OFF_LVDTHR, 32'h0000_000A);
        rd_chk("lvdthr", `SRC_OFF_LVDTHR, 32'h0000_000A);
        `CHK("lvd_threshold", 4'hA, lvd_thr)
        for (int pm = 0; pm < 4; pm++) begin
            wr(`SRC_OFF_CTRL, 32'(pm) << 4);
            repeat (3) @(posedge pclk);
            `CHK("osc_en", pm < 2, osc_en)
        end
        // The detector alone must not reset while the low voltage reset is off.
        wr(`SRC_OFF_CTRL, 32'h0000_0070);
        i_partner.set_levels(4'b0001);
        repeat (20) @(posedge pclk);
        `CHK("sys_rst_n", 1'b1, sys_rst_n)
        `CHK("clk_sel_ext", 1'b1, clk_ext)
        i_partner.set_levels(4'h0);
        wr(`SRC_OFF_CTRL, 32'h0000_0071);
        cycle_src(4'b0001);
        wr(`SRC_OFF_CTRL, 32'h0000_0002);
        cycle_src(4'b0010);
        cycle_src(4'b1000);
        cycle_src(4'b0100);
        i_partner.press(1200);
        repeat (20) @(posedge pclk);
        `CHK("sys_rst_n", 1'b1, sys_rst_n)
        i_partner.press(12500);
        `CHK("sys_rst_n", 1'b0, sys_rst_n)
        boot();
        wr(`SRC_OFF_WDTLOAD, 32'h0000_0064);
        wr(`SRC_OFF_WDTKICK, 32'h0000_0000);
        wr(`SRC_OFF_CTRL, 32'h0000_000C);
        repeat (2) @(posedge pclk);
        `CHK("watchdog_en", 1'b1, wdt_en)
        wait_rst(1'b0, 200);
        `CHK("sys_rst_n", 1'b0, sys_rst_n)
        boot();
        rd_chk("unmapped", 12'h014, 32'h0000_0000);
        `CHK("pslverr", 1'b1, pslverr)
        // Every source has fired once; the cause flags are sticky until cleared.
        rd_chk("status", `SRC_OFF_STATUS, 32'h0000_002F);
        wr(`SRC_OFF_STATUS, 32'h0000_000F);
        rd_chk("status_clr", `SRC_OFF_STATUS, 32'h0000_0020);
        report_and_stop();
    end
endmodule : tb
